// >>> rtl/hbwla_pkg.sv
// Behaviour
// - The bus width, 32-bit or 16-bit, follows the level of an external strap caught once as static configuration.
// - The strapped width reads back as a read-only bit at position 2 of the hardware configuration word.
// - The two half-word writes of a DWORD are accepted in either order if the second hits the other half.
// - A second half-word write to the same half as the first is discarded and no DWORD is completed.
// - In 16-bit mode a DWORD is read as two consecutive half-word reads, either half first.
// - Two successive reads of the same half return invalid data and restart the read pair on the next read.
// - In 16-bit mode the upper sixteen data lines are never driven.
// - In 32-bit mode byte 3 sits on lines 31 to 24 and byte 0 on lines 7 to 0, bytes 2 and 1 between.
// - With the word-swap value all ones, 16-bit mode gives bytes 3:2 at A1=0 and bytes 1:0 at A1=1.
// - With any other word-swap value, 16-bit mode gives bytes 1:0 at A1=0 and bytes 3:2 at A1=1.
package hbwla_pkg;

  // ----------------------------------------------------------------
  // configuration word
  // ----------------------------------------------------------------
  localparam int HARDWARE_CONFIG_REGISTER_WIDTH_BIT = 2;
  localparam logic [31:0] HARDWARE_CONFIG_REGISTER_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // strap and swap encodings
  // ----------------------------------------------------------------
  localparam logic STRAP_WIDTH_32 = 1'b1;
  localparam logic [31:0] SWAP_ALL_ONES = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] HALF_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam int SYNC_STAGES = 2;

endpackage : hbwla_pkg

// >>> rtl/hbwla_sync.sv
`timescale 1ns/1ps
module hbwla_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] rst_val_i,
  output logic [WIDTH-1:0] sync_o
);

  // ----------------------------------------------------------------
  // two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge mclk_i)
  begin
    meta_q <= async_i;
    sync_q <= meta_q;
  end

  assign sync_o = sync_q;

endmodule : hbwla_sync

// >>> rtl/hbwla_top.sv
`timescale 1ns/1ps
module hbwla_top #(
  parameter int AW = 8
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic bus_width_strap_pin_i,
  input wire logic [31:0] word_swap_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [AW-1:1] addr_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic data_lo_oe_o,
  output logic data_hi_oe_o,
  output logic [31:0] hardware_config_register_o,
  output logic width_select_strap_o,
  output logic [AW-1:2] int_addr_o,
  output logic int_wr_o,
  output logic [31:0] int_wdata_o,
  output logic int_rd_o,
  input wire logic [31:0] int_rdata_i,
  output logic wr_discard_o,
  output logic rd_invalid_o
);

  // strap, three strobes, half address and data
  localparam int SW = 4 + (AW - 1) + 32;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when the host half address selects logical bytes 3:2
  function automatic logic half_is_upper(input logic a1,
                                         input logic [31:0] swap);
    if (swap == hbwla_pkg::SWAP_ALL_ONES)
      half_is_upper = ~a1;
    else
      half_is_upper = a1;
  endfunction : half_is_upper

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic [SW-1:0] pins_rst;
  logic strap_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [AW-1:1] addr_s;
  logic [31:0] din_s;

  assign pins_raw = {bus_width_strap_pin_i, cs_n_i, rd_n_i, wr_n_i,
                     addr_i, data_i};
  assign pins_rst = '0;

  hbwla_sync #(
    .WIDTH(SW)
  ) u_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .async_i(pins_raw),
    .rst_val_i(pins_rst),
    .sync_o(pins_s)
  );

  assign din_s = pins_s[31:0];
  assign addr_s = pins_s[32 +: (AW - 1)];
  assign wr_n_s = pins_s[AW + 31];
  assign rd_n_s = pins_s[AW + 32];
  assign cs_n_s = pins_s[AW + 33];
  assign strap_s = pins_s[AW + 34];

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic width32_q;
  logic cfg_done_q;

  // caught once after reset release, then held as static config
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      width32_q <= 1'b0;
      cfg_done_q <= 1'b0;
    end
    else if (!cfg_done_q)
    begin
      width32_q <= (strap_s == hbwla_pkg::STRAP_WIDTH_32);
      cfg_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration word
  // ----------------------------------------------------------------
  logic [31:0] hardware_config_register_q;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      hardware_config_register_q <= hbwla_pkg::HARDWARE_CONFIG_REGISTER_RESET;
    else
    begin
      hardware_config_register_q <= hbwla_pkg::HARDWARE_CONFIG_REGISTER_RESET;
      hardware_config_register_q[hbwla_pkg::HARDWARE_CONFIG_REGISTER_WIDTH_BIT] <= width32_q;
    end
  end

  assign hardware_config_register_o = hardware_config_register_q;
  assign width_select_strap_o = width32_q;

  // ----------------------------------------------------------------
  // strobe edges
  // ----------------------------------------------------------------
  logic rd_act;
  logic wr_act;
  logic rd_act_q;
  logic wr_act_q;
  logic rd_start;
  logic wr_start;
  logic upper;

  assign rd_act = ~cs_n_s & ~rd_n_s;
  assign wr_act = ~cs_n_s & ~wr_n_s;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end
    else
    begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  assign rd_start = rd_act & ~rd_act_q & cfg_done_q;
  assign wr_start = wr_act & ~wr_act_q & cfg_done_q & ~rd_start;
  assign upper = half_is_upper(addr_s[1], word_swap_i);

  // ----------------------------------------------------------------
  // write pairing
  // ----------------------------------------------------------------
  logic wpend_q;
  logic wupper_q;
  logic [15:0] wstage_q;
  logic w_other_half;

  assign w_other_half = wpend_q & (upper != wupper_q);

  // first half is staged until the other half completes the DWORD
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      wpend_q <= 1'b0;
      wupper_q <= 1'b0;
      wstage_q <= hbwla_pkg::HALF_RESET;
    end
    else if (wr_start && !width32_q)
    begin
      if (!wpend_q)
      begin
        wpend_q <= 1'b1;
        wupper_q <= upper;
        wstage_q <= din_s[15:0];
      end
      else
        wpend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read pairing
  // ----------------------------------------------------------------
  logic rpend_q;
  logic rupper_q;
  logic [31:0] rlatch_q;
  logic r_other_half;

  assign r_other_half = rpend_q & (upper != rupper_q);

  // a same-half second read drops the pair; the next read starts anew
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rpend_q <= 1'b0;
      rupper_q <= 1'b0;
      rlatch_q <= hbwla_pkg::WORD_RESET;
    end
    else if (rd_start && !width32_q)
    begin
      if (!rpend_q)
      begin
        rpend_q <= 1'b1;
        rupper_q <= upper;
        rlatch_q <= int_rdata_i;
      end
      else
        rpend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // internal port
  // ----------------------------------------------------------------
  logic int_wr_q;
  logic int_rd;
  logic [31:0] int_wdata_q;
  logic [AW-1:2] int_waddr_q;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      int_wr_q <= 1'b0;
      int_wdata_q <= hbwla_pkg::WORD_RESET;
      int_waddr_q <= '0;
    end
    else
    begin
      int_wr_q <= 1'b0;
      if (wr_start && width32_q)
      begin
        int_wr_q <= 1'b1;
        int_wdata_q <= din_s;
        int_waddr_q <= addr_s[AW-1:2];
      end
      else if (wr_start && w_other_half)
      begin
        int_wr_q <= 1'b1;
        int_waddr_q <= addr_s[AW-1:2];
        if (upper)
          int_wdata_q <= {din_s[15:0], wstage_q};
        else
          int_wdata_q <= {wstage_q, din_s[15:0]};
      end
    end
  end

  // a fetch is needed for every 32-bit read and for each pair's first half
  assign int_rd = rd_start & (width32_q | ~rpend_q);
  assign int_rd_o = int_rd;
  assign int_wr_o = int_wr_q;
  assign int_wdata_o = int_wdata_q;
  assign int_addr_o = int_rd ? addr_s[AW-1:2] : int_waddr_q;

  // ----------------------------------------------------------------
  // error pulses
  // ----------------------------------------------------------------
  logic wr_discard_q;
  logic rd_invalid_q;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      wr_discard_q <= 1'b0;
      rd_invalid_q <= 1'b0;
    end
    else
    begin
      wr_discard_q <= wr_start & ~width32_q & wpend_q & ~w_other_half;
      rd_invalid_q <= rd_start & ~width32_q & rpend_q & ~r_other_half;
    end
  end

  assign wr_discard_o = wr_discard_q;
  assign rd_invalid_o = rd_invalid_q;

  // ----------------------------------------------------------------
  // read data and lane drive
  // ----------------------------------------------------------------
  logic [31:0] dout_q;
  logic oe_q;
  logic [31:0] rsrc;

  assign rsrc = rpend_q ? rlatch_q : int_rdata_i;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      dout_q <= hbwla_pkg::WORD_RESET;
    else if (rd_start)
    begin
      if (width32_q)
        dout_q <= int_rdata_i;
      else if (upper)
        dout_q <= {16'h0000, rsrc[31:16]};
      else
        dout_q <= {16'h0000, rsrc[15:0]};
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      oe_q <= 1'b0;
    else
      oe_q <= rd_act & cfg_done_q;
  end

  assign data_o = dout_q;
  assign data_lo_oe_o = oe_q;
  assign data_hi_oe_o = oe_q & width32_q;

endmodule : hbwla_top

// >>> dv/hbwla_top_asserts.sv
`timescale 1ns/1ps
module hbwla_top_asserts (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [31:0] data_o,
  input wire logic data_lo_oe_o,
  input wire logic data_hi_oe_o,
  input wire logic [31:0] hardware_config_register_o,
  input wire logic width_select_strap_o,
  input wire logic int_wr_o,
  input wire logic int_rd_o,
  input wire logic [31:0] int_rdata_i,
  input wire logic wr_discard_o,
  input wire logic rd_invalid_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  chk_cfg_width: assert property (
    hardware_config_register_o == {29'h0, $past(width_select_strap_o), 2'h0})
    else $error("config word wrong");
  chk_hi_idle: assert property (
    !width_select_strap_o |-> !data_hi_oe_o && data_o[31:16] == 16'h0)
    else $error("upper lanes active in narrow mode");
  chk_fetch_data: assert property (
    int_rd_o && width_select_strap_o |=> data_o == $past(int_rdata_i))
    else $error("read word not on lanes");
  chk_fetch_oe: assert property (int_rd_o |=> data_lo_oe_o)
    else $error("read not driven");
  chk_discard_quiet: assert property (
    wr_discard_o |-> !int_wr_o && !width_select_strap_o)
    else $error("discard with commit");
  chk_commit_pulse: assert property (int_wr_o |=> !int_wr_o [*3])
    else $error("commit not single");
  chk_inval_nofetch: assert property (rd_invalid_o |-> !$past(int_rd_o))
    else $error("invalid read fetched");
  chk_hi_with_lo: assert property (
    data_hi_oe_o |-> data_lo_oe_o && width_select_strap_o)
    else $error("upper enable alone");
endmodule : hbwla_top_asserts

// >>> dv/hbwla_host.sv
`timescale 1ns/1ps
module hbwla_host (
  input wire logic mclk_i,
  input wire logic [31:0] rdata_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:1] addr_o,
  output logic [31:0] wdata_o
);
  initial
  begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 7'h00;
    wdata_o = 32'h0;
  end
  // strobes low 6 cycles then high 4; lines inverted once released
  task automatic xfer(input logic rd, input logic [7:1] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = d;
    cs_n_o = 1'b0;
    rd_n_o = ~rd;
    wr_n_o = rd;
    repeat (6) @(negedge mclk_i);
    q = rdata_i;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = ~a;
    wdata_o = ~d;
    repeat (4) @(negedge mclk_i);
  endtask : xfer
endmodule : hbwla_host

// >>> dv/hbwla_test.sv
`timescale 1ns/1ps
module hbwla_test;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic strap = 1'b1;
  logic [31:0] swap = 32'h0;
  logic cs_n, rd_n, wr_n, lo_oe, hi_oe, wsel, iwr, ird, disc, inval, f;
  logic [7:1] addr;
  logic [7:2] iaddr;
  logic [31:0] wdata, rdata, irdata, iwdata, cfg, w, q;
  logic [31:0] mem [64];
  logic [5:0] a;
  int fail_count = 0, num_checks = 0, ncom = 0, ndisc = 0, ninv = 0;
  int cyc = 0, n, m;
  always #5 mclk_i = ~mclk_i;
  assign irdata = mem[iaddr];
  hbwla_host host (.mclk_i(mclk_i), .rdata_i(rdata), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
  hbwla_top #(.AW(8)) uut (.mclk_i(mclk_i), .srst_i(srst_i),
    .bus_width_strap_pin_i(strap), .word_swap_i(swap), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata),
    .data_o(rdata), .data_lo_oe_o(lo_oe), .data_hi_oe_o(hi_oe),
    .hardware_config_register_o(cfg), .width_select_strap_o(wsel),
    .int_addr_o(iaddr), .int_wr_o(iwr), .int_wdata_o(iwdata),
    .int_rd_o(ird), .int_rdata_i(irdata), .wr_discard_o(disc),
    .rd_invalid_o(inval));
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (iwr === 1'b1)
    begin
      mem[iaddr] <= iwdata;
      ncom <= ncom + 1;
    end
    if (disc === 1'b1)
      ndisc <= ndisc + 1;
    if (inval === 1'b1)
      ninv <= ninv + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check
  function automatic logic [31:0] lane(input logic [31:0] v, input logic a1);
    return ((swap == 32'hFFFF_FFFF) ^ a1) ? v[31:16] : v[15:0];
  endfunction : lane
  task automatic do_reset(input logic s);
    @(negedge mclk_i);
    strap = s;
    srst_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask : do_reset
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    n = $urandom(74);
    foreach (mem[i])
      mem[i] = $urandom;
    do_reset(1'b1);
    check("cfg", 32'h4, cfg);
    for (int i = 0; i < 4; i++)
    begin
      a = 6'($urandom);
      w = $urandom;
      host.xfer(1'b0, {a, 1'b0}, w, q);
      check("wr32", w, mem[a]);
      a = 6'($urandom);
      w = mem[a];
      host.xfer(1'b1, {a, 1'b1}, 32'h0, q);
      check("rd32", w, q);
    end
    $display("wide mode done");
    for (int s = 0; s < 2; s++)
    begin
      swap = s ? 32'hFFFF_FFFF : 32'hFFFF_FFFE;
      do_reset(1'b0);
      check("cfg", 32'h0, cfg);
      for (int i = 0; i < 4; i++)
      begin
        a = 6'($urandom);
        w = $urandom;
        f = i[0];
        n = ncom;
        host.xfer(1'b0, {a, f}, lane(w, f), q);
        check("staged", n, ncom);
        host.xfer(1'b0, {a, ~f}, lane(w, ~f), q);
        check("wr16", w, mem[a]);
        a = 6'($urandom);
        host.xfer(1'b1, {a, ~f}, 32'h0, q);
        check("rd1", lane(mem[a], ~f), q);
        host.xfer(1'b1, {a, f}, 32'h0, q);
        check("rd2", lane(mem[a], f), q);
      end
      n = ncom;
      m = ndisc;
      host.xfer(1'b0, {a, f}, $urandom, q);
      host.xfer(1'b0, {a, f}, $urandom, q);
      check("discard", m + 1, ndisc);
      check("nocommit", n, ncom);
      m = ninv;
      host.xfer(1'b1, {a, f}, 32'h0, q);
      host.xfer(1'b1, {a, f}, 32'h0, q);
      check("invalid", m + 1, ninv);
      host.xfer(1'b1, {a, ~f}, 32'h0, q);
      check("restart", lane(mem[a], ~f), q);
      $display("narrow mode pass %0d done", s);
    end
    tally_and_finish();
  end
endmodule : hbwla_test
bind hbwla_top hbwla_top_asserts u_chk (.mclk_i(mclk_i), .srst_i(srst_i),
  .data_o(data_o), .data_lo_oe_o(data_lo_oe_o),
  .data_hi_oe_o(data_hi_oe_o),
  .hardware_config_register_o(hardware_config_register_o),
  .width_select_strap_o(width_select_strap_o), .int_wr_o(int_wr_o),
  .int_rd_o(int_rd_o), .int_rdata_i(int_rdata_i),
  .wr_discard_o(wr_discard_o), .rd_invalid_o(rd_invalid_o));
